// *** hw/bit_clear_unit.v ***
// Combinational bit-clear datapath for byte, word and longword operands.
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.vh"
module bit_clear_unit (
  input  wire [31:0] operand,
  input  wire [4:0]  bit_num,
  input  wire [1:0]  size,
  output reg  [31:0] result
);
  // Effective bit index after masking to the operand width.
  reg [4:0] idx;
  // Clears exactly one bit; higher bits of the bit number are ignored.
  always @* begin
    case (size)
      `SIZE_BYTE: idx = bit_num & `BITNUM_MASK_BYTE;
      `SIZE_WORD: idx = bit_num & `BITNUM_MASK_WORD;
      default:    idx = bit_num & `BITNUM_MASK_LONG;
    endcase
    result = operand & ~(32'h00000001 << idx);
  end
endmodule
`default_nettype wire

// *** hw/exec_map.vh ***
// Opcode fields, size codes and step constants for the purge, push and bit-clear executor.
`ifndef EXEC_MAP_VH
`define EXEC_MAP_VH
`define EXT_PREFIX        8'h7A
`define OPLO_PURGE_ND     8'h39
`define OPLO_PURGE_NI     8'h29
`define OPLO_PURGE_SD     8'h19
`define OPLO_PURGE_SI     8'h09
`define OPLO_PURGE_NORMAL 8'h0B
`define SPACE_ND          2'h3
`define SPACE_NI          2'h2
`define SPACE_SD          2'h1
`define SPACE_SI          2'h0
`define SIZE_BYTE         2'h0
`define SIZE_WORD         2'h1
`define SIZE_LONG         2'h2
`define PUSH_DEC_WORD     32'h00000002
`define PUSH_DEC_LONG     32'h00000004
`define BITNUM_MASK_BYTE  5'h07
`define BITNUM_MASK_WORD  5'h0F
`define BITNUM_MASK_LONG  5'h1F
`define TLB_ENTRIES       8
`define TLB_IDX_W         3
`define PAGE_W            20
`endif

// *** hw/tlb_purge_push_bit_clear_exec.v ***
// Executor for translation purges, stack pushes and bit-clear instructions.
// Summary of operation
// - Single purge invalidates entries matching the address and the decoded space.
// - Decode four purge spaces from opcode low byte.
// - Purge address via register-indirect or effective address.
// - Purges privileged; trap otherwise, flags untouched.
// - Normal-space purge drops normal data/instruction entries.
// - Push decrements pointer by two or four.
// - Push writes at the already-decremented pointer.
// - Zero pointer field is not a push.
// - Effective-address push fetches one to three extension words.
// - Bit clear zeroes selected bit, keeps others.
// - Bit number immediate or from word register.
// - Bit number masked to three, four, five bits.
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.vh"
module tlb_purge_push_bit_clear_exec (
  input  wire        clk,
  input  wire        reset,
  input  wire        start,
  input  wire [1:0]  op_class,
  input  wire [7:0]  op_low,
  input  wire        system_mode,
  input  wire [31:0] ea_addr,
  input  wire        reg_indirect,
  input  wire [3:0]  reg_field,
  input  wire [1:0]  size,
  input  wire [31:0] ptr_value,
  input  wire [31:0] src_value,
  input  wire [1:0]  ext_words,
  input  wire        dyn_bit,
  input  wire [4:0]  imm_bit,
  input  wire [15:0] bit_reg,
  input  wire        tlb_fill,
  input  wire [1:0]  fill_space,
  input  wire [31:0] fill_addr,
  output reg         ext_fetch,
  output reg         ptr_we,
  output reg  [31:0] ptr_new,
  output reg         mem_we,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_data,
  output reg         dst_we,
  output reg  [31:0] dst_data,
  output reg         priv_trap,
  output reg         illegal,
  output reg         done,
  output reg  [`TLB_ENTRIES-1:0] tlb_valid
);
  // Operation classes presented on op_class.
  localparam CL_PURGE = 2'h0;
  localparam CL_PUSH  = 2'h1;
  localparam CL_BCLR  = 2'h2;
  // Sequencer states.
  localparam ST_IDLE  = 2'h0;
  localparam ST_EXT   = 2'h1;
  localparam ST_WRITE = 2'h2;

  reg  [1:0]  state_q;                      // Sequencer state.
  reg  [1:0]  ext_left_q;                   // Extension words still to fetch.
  reg  [31:0] dec_ptr_q;                    // Decremented stack pointer.
  reg  [31:0] push_val_q;                   // Value to push.
  reg  [`TLB_IDX_W-1:0] fill_ptr_q;         // Round-robin fill slot.
  reg  [`PAGE_W-1:0] tag_q [0:`TLB_ENTRIES-1]; // Page tags.
  reg  [1:0]  spc_q [0:`TLB_ENTRIES-1];     // Address space of each entry.
  wire [31:0] clr_result;                   // Bit-clear result.
  wire [4:0]  bit_sel;                      // Chosen bit number.
  wire [31:0] dec_amt;                      // Push decrement.
  reg  [1:0]  purge_space;                  // Decoded purge space.
  reg         purge_one;                    // Single-entry purge decoded.
  reg         purge_norm;                   // Normal-space purge decoded.

  // Dynamic form takes bit number from a word register.
  assign bit_sel = dyn_bit ? bit_reg[4:0] : imm_bit;
  assign dec_amt = (size == `SIZE_LONG) ? `PUSH_DEC_LONG : `PUSH_DEC_WORD;

  bit_clear_unit u_clr (
    .operand (src_value),
    .bit_num (bit_sel),
    .size    (size),
    .result  (clr_result)
  );

  // Decodes the purge variant from the opcode low byte.
  always @* begin
    purge_one   = 1'b1;
    purge_norm  = 1'b0;
    purge_space = `SPACE_SI;
    case (op_low)
      `OPLO_PURGE_ND: purge_space = `SPACE_ND;
      `OPLO_PURGE_NI: purge_space = `SPACE_NI;
      `OPLO_PURGE_SD: purge_space = `SPACE_SD;
      `OPLO_PURGE_SI: purge_space = `SPACE_SI;
      `OPLO_PURGE_NORMAL: begin
        purge_one  = 1'b0;
        purge_norm = 1'b1;
      end
      default: purge_one = 1'b0;
    endcase
  end

  // Translation buffer state; one process per entry.
  genvar gi;
  generate
    for (gi = 0; gi < `TLB_ENTRIES; gi = gi + 1) begin : g_tlb
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          tlb_valid[gi] <= 1'b0;
          tag_q[gi]     <= {`PAGE_W{1'b0}};
          spc_q[gi]     <= 2'h0;
        end else if (state_q == ST_IDLE && start && op_class == CL_PURGE &&
                     system_mode && !(purge_one && reg_indirect && reg_field == 4'h0)) begin
          // Purge only proceeds in system mode, so a trapped purge invalidates no entry.
          if (purge_one && tag_q[gi] == ea_addr[31:32-`PAGE_W] &&
              spc_q[gi] == purge_space) begin
            tlb_valid[gi] <= 1'b0;
          end else if (purge_norm && spc_q[gi][1]) begin
            tlb_valid[gi] <= 1'b0;
          end
        end else if (tlb_fill && fill_ptr_q == gi) begin
          // Fill from the translation walker.
          tlb_valid[gi] <= 1'b1;
          tag_q[gi]     <= fill_addr[31:32-`PAGE_W];
          spc_q[gi]     <= fill_space;
        end
      end
    end
  endgenerate

  // Instruction sequencer.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q    <= ST_IDLE;
      ext_left_q <= 2'h0;
      dec_ptr_q  <= 32'h00000000;
      push_val_q <= 32'h00000000;
      fill_ptr_q <= {`TLB_IDX_W{1'b0}};
      ext_fetch  <= 1'b0;
      ptr_we     <= 1'b0;
      ptr_new    <= 32'h00000000;
      mem_we     <= 1'b0;
      mem_addr   <= 32'h00000000;
      mem_data   <= 32'h00000000;
      dst_we     <= 1'b0;
      dst_data   <= 32'h00000000;
      priv_trap  <= 1'b0;
      illegal    <= 1'b0;
      done       <= 1'b0;
    end else begin
      // Pulses default low each cycle.
      ext_fetch <= 1'b0;
      ptr_we    <= 1'b0;
      mem_we    <= 1'b0;
      dst_we    <= 1'b0;
      priv_trap <= 1'b0;
      illegal   <= 1'b0;
      done      <= 1'b0;
      if (tlb_fill) begin
        fill_ptr_q <= fill_ptr_q + 1'b1;
      end
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            case (op_class)
              CL_PURGE: begin
                if (!(purge_one || purge_norm)) begin
                  illegal <= 1'b1;
                  done    <= 1'b1;
                end else if (!system_mode) begin
                  // Trap in normal mode; no flag output exists to change.
                  priv_trap <= 1'b1;
                  done      <= 1'b1;
                end else if (purge_one && reg_indirect && reg_field == 4'h0) begin
                  illegal <= 1'b1;
                  done    <= 1'b1;
                end else begin
                  done <= 1'b1;
                end
              end
              CL_PUSH: begin
                if (reg_field == 4'h0) begin
                  illegal <= 1'b1;
                  done    <= 1'b1;
                end else begin
                  // Decrement first; memory write follows in a later cycle.
                  dec_ptr_q  <= ptr_value - dec_amt;
                  ptr_new    <= ptr_value - dec_amt;
                  ptr_we     <= 1'b1;
                  push_val_q <= (size == `SIZE_LONG) ? src_value :
                                {16'h0000, src_value[15:0]};
                  ext_left_q <= ext_words;
                  if (ext_words != 2'h0) begin
                    state_q <= ST_EXT;
                  end else begin
                    state_q <= ST_WRITE;
                  end
                end
              end
              CL_BCLR: begin
                if (dyn_bit && (reg_indirect || ext_words != 2'h0)) begin
                  illegal <= 1'b1;
                  done    <= 1'b1;
                end else begin
                  dst_data <= clr_result;
                  dst_we   <= 1'b1;
                  done     <= 1'b1;
                end
              end
              default: begin
                illegal <= 1'b1;
                done    <= 1'b1;
              end
            endcase
          end
        end
        ST_EXT: begin
          // One extension word fetched per cycle.
          ext_fetch  <= 1'b1;
          ext_left_q <= ext_left_q - 1'b1;
          if (ext_left_q == 2'h1) begin
            state_q <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          mem_addr <= dec_ptr_q;
          mem_data <= push_val_q;
          mem_we   <= 1'b1;
          done     <= 1'b1;
          state_q  <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verification/exec_checker.sv ***
// Port-level assertions for the purge, push and bit-clear executor.
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.vh"
module exec_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        start,
  input wire logic [1:0]  op_class,
  input wire logic        system_mode,
  input wire logic        reg_indirect,
  input wire logic [3:0]  reg_field,
  input wire logic [1:0]  size,
  input wire logic [31:0] ptr_value,
  input wire logic [31:0] src_value,
  input wire logic [1:0]  ext_words,
  input wire logic        dyn_bit,
  input wire logic [4:0]  imm_bit,
  input wire logic [15:0] bit_reg,
  input wire logic        ext_fetch,
  input wire logic        ptr_we,
  input wire logic [31:0] ptr_new,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic        dst_we,
  input wire logic [31:0] dst_data,
  input wire logic        priv_trap,
  input wire logic        illegal,
  input wire logic        done,
  input wire logic [`TLB_ENTRIES-1:0] tlb_valid
);
  logic [4:0]  bidx;  // Bit number after the size mask.
  logic [31:0] exp_q; // Operand with that bit cleared, one cycle late.
  assign bidx = (dyn_bit ? bit_reg[4:0] : imm_bit) & (size == `SIZE_BYTE ? `BITNUM_MASK_BYTE :
    size == `SIZE_WORD ? `BITNUM_MASK_WORD : `BITNUM_MASK_LONG);
  // The expectation tracks inputs so it lines up with the registered result.
  always_ff @(posedge clk) exp_q <= src_value & ~(32'h00000001 << bidx);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_push_go; start && op_class == 2'h1 && reg_field != 4'h0; endsequence
  sequence s_store; mem_we && done; endsequence
  a_dec_amount: assert property (ptr_we |-> ptr_new == $past(ptr_value) -
    ($past(size) == `SIZE_LONG ? `PUSH_DEC_LONG : `PUSH_DEC_WORD)) else $error("bad decrement");
  a_write_at_ptr: assert property (mem_we |-> mem_addr == ptr_new) else $error("bad address");
  a_dec_first: assert property (s_push_go |=> (ptr_we && !mem_we) ##[1:4] s_store)
    else $error("write not after decrement");
  a_ext_order: assert property (s_push_go ##0 ext_words == 2'h1 |=> ptr_we ##1 ext_fetch
    ##1 (s_store and !ext_fetch)) else $error("extension fetch order");
  a_zero_ptr: assert property (start && op_class == 2'h1 && reg_field == 4'h0 |=>
    illegal && done && !ptr_we) else $error("zero pointer pushed");
  a_bit_clear: assert property (dst_we |-> dst_data == exp_q) else $error("bad clear");
  a_trap_normal: assert property (start && op_class == 2'h0 && !system_mode &&
    !reg_indirect |=> priv_trap && done) else $error("missing trap");
  a_trap_keeps: assert property (priv_trap |-> tlb_valid == $past(tlb_valid))
    else $error("trap invalidated entry");
  a_purge_answer: assert property (start && op_class == 2'h0 |=> done) else $error("no done");
endmodule
bind tlb_purge_push_bit_clear_exec exec_checker u_exec_checker (.*);
`default_nettype wire

// *** verification/mem_model.sv ***
// Memory-side model that records stack writes and extension fetches.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_data,
  input wire logic        ext_fetch,
  output var logic [31:0] last_addr,
  output var logic [31:0] last_data,
  output var logic [7:0]  n_ext
);
  // Keep the last stored word and a running count of fetched words.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last_addr <= 32'h00000000;
      last_data <= 32'h00000000;
      n_ext <= 8'h00;
    end else begin
      if (mem_we) begin
        last_addr <= mem_addr;
        last_data <= mem_data;
      end
      if (ext_fetch) n_ext <= n_ext + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** verification/tlb_purge_push_bit_clear_exec_bench.sv ***
// Self-checking bench for the purge, push and bit-clear executor.
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.vh"
module tlb_purge_push_bit_clear_exec_bench;
  logic        clk, reset, start, system_mode, reg_indirect, dyn_bit, tlb_fill;
  logic        ext_fetch, ptr_we, mem_we, dst_we, priv_trap, illegal, done;
  logic [1:0]  op_class, size, ext_words, fill_space;
  logic [3:0]  reg_field;
  logic [4:0]  imm_bit;
  logic [7:0]  op_low, n_ext, tlb_valid;
  logic [15:0] bit_reg;
  logic [31:0] ea_addr, ptr_value, src_value, fill_addr, ptr_new, mem_addr, mem_data;
  logic [31:0] dst_data, last_addr, last_data;
  int          n_fail, comparisons, lat;
  tlb_purge_push_bit_clear_exec u_tlb_purge_push_bit_clear_exec (.*);
  mem_model u_mem_model (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Pulse start for one cycle and count cycles until done, with a bound.
  // The cycle right after the start edge counts as cycle one.
  task automatic go();
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    lat = 1;
    while (done !== 1'b1 && lat < 9) begin
      @(negedge clk);
      lat++;
    end
    if (done !== 1'b1) begin
      n_fail++;
      end_sim();
    end
  endtask
  // Fill five entries, then purge space by space, trapping and refusing.
  task automatic t_purge();
    logic [7:0] ops [8] = '{8'h39, 8'h29, 8'h29, 8'h09, 8'h19, 8'h0B, 8'h55, 8'h39};
    logic [7:0] tv [8] = '{8'h1E, 8'h1E, 8'h1C, 8'h1C, 8'h18, 8'h08, 8'h08, 8'h08};
    logic [1:0] fl [8] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1};
    logic [1:0] sp [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h2};
    tlb_fill = 1'b1;
    for (int i = 0; i < 5; i++) begin
      fill_space = sp[i];
      fill_addr = (i < 3) ? 32'h00012000 : {12'h000, 4'(i), 16'h4000};
      @(negedge clk);
    end
    tlb_fill = 1'b0;
    chk(tlb_valid, 8'h1F);
    op_class = 2'h0;
    for (int i = 0; i < 8; i++) begin
      op_low = ops[i];
      system_mode = (i != 1);
      reg_indirect = (i == 7);
      ea_addr = (i == 0) ? 32'h00012ABC : 32'h00012000;
      go();
      chk(tlb_valid, tv[i]);
      chk({priv_trap, illegal}, fl[i]);
      chk(lat, 1);
    end
    reg_indirect = 1'b0;
    $display("purge test ended");
  endtask
  // One push: pointer, stored address and data, fetch count and latency.
  task automatic push1(input logic [1:0] sz, input logic [1:0] ext, input logic [31:0] p,
                       input logic [31:0] d, input logic [31:0] xd);
    logic [7:0]  e0;
    logic [31:0] np;
    e0 = n_ext;
    np = p - ((sz == `SIZE_LONG) ? 32'h00000004 : 32'h00000002);
    op_class = 2'h1;
    size = sz;
    ext_words = ext;
    ptr_value = p;
    src_value = d;
    reg_field = 4'hC;
    go();
    chk(ptr_new, np);
    // The memory model takes the store at the edge after done shows.
    @(negedge clk);
    chk(last_addr, np);
    chk(last_data, xd);
    chk(n_ext - e0, ext);
    chk(lat, 2 + ext);
  endtask
  // Back-to-back pushes, then a zero pointer that must be refused.
  task automatic t_push();
    push1(`SIZE_WORD, 2'h1, 32'h00001002, 32'h12340022, 32'h00000022);
    push1(`SIZE_LONG, 2'h0, 32'h00002000, 32'hCAFE0001, 32'hCAFE0001);
    push1(`SIZE_LONG, 2'h3, 32'h00000008, 32'h00000005, 32'h00000005);
    reg_field = 4'h0;
    go();
    chk(illegal, 1'b1);
    chk(last_addr, 32'h00000004);
    ext_words = 2'h0;
    $display("push test ended");
  endtask
  // One bit clear with the given size, form and bit number.
  task automatic clr1(input logic [1:0] sz, input logic dy, input logic [15:0] b,
                      input logic [31:0] d, input logic [31:0] x);
    op_class = 2'h2;
    size = sz;
    dyn_bit = dy;
    imm_bit = b[4:0];
    bit_reg = b;
    src_value = d;
    go();
    chk(dst_data, x);
    chk(lat, 1);
  endtask
  task automatic t_bitclr();
    clr1(`SIZE_BYTE, 1'b0, 16'h0009, 32'h000000B2, 32'h000000B0);
    clr1(`SIZE_WORD, 1'b1, 16'h0013, 32'h0000FFFF, 32'h0000FFF7);
    clr1(`SIZE_LONG, 1'b0, 16'h001F, 32'hFFFFFFFF, 32'h7FFFFFFF);
    clr1(`SIZE_WORD, 1'b0, 16'h0010, 32'h0000FFFF, 32'h0000FFFE);
    // Dynamic form with an indirect destination is refused and writes nothing.
    dyn_bit = 1'b1;
    reg_indirect = 1'b1;
    go();
    chk(illegal, 1'b1);
    chk(dst_data, 32'h0000FFFE);
    reg_indirect = 1'b0;
    dyn_bit = 1'b0;
    $display("bit clear test ended");
  endtask
  initial begin
    {start, system_mode, reg_indirect, dyn_bit, tlb_fill} = 5'h00;
    {op_class, size, ext_words, fill_space, reg_field} = 12'h000;
    {op_low, imm_bit, bit_reg} = 29'h00000000;
    {ea_addr, ptr_value, src_value, fill_addr} = 128'h0;
    n_fail = 0;
    comparisons = 0;
    reset = 1'b1;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    t_purge();
    t_push();
    t_bitclr();
    end_sim();
  end
endmodule
`default_nettype wire
